// *** design/ctbx_regs.svh ***
// Constants for the transfer, bit and control execution block.
// Assumes inclusion from the core module, the checker and the bench only.
`ifndef CTBX_REGS_SVH
`define CTBX_REGS_SVH
`define CTBX_ADDR_CTRL 32'h0000_0000
`define CTBX_ADDR_INSN 32'h0000_0004
`define CTBX_ADDR_OPS 32'h0000_0008
`define CTBX_ADDR_FLAGS 32'h0000_000C
`define CTBX_ADDR_STAT 32'h0000_0010
`define CTBX_ADDR_PTR 32'h0000_0014
`define CTBX_ADDR_RESULT 32'h0000_0018
`define CTBX_ADDR_MEMOUT 32'h0000_001C
`define CTBX_ADDR_SIDE 32'h0000_0020
`define CTBX_FLAG_C 0
`define CTBX_FLAG_Z 1
`define CTBX_FLAG_N 2
`define CTBX_FLAG_V 3
`define CTBX_FLAG_S 4
`define CTBX_FLAG_H 5
`define CTBX_FLAG_T 6
`define CTBX_FLAG_I 7
`define CTBX_FLAGS_RESET 8'h00
`define CTBX_CYC_ONE 2'h1
`define CTBX_CYC_TWO 2'h2
`define CTBX_CYC_THREE 2'h3
`define CTBX_RESP_OKAY 2'h0
`define CTBX_RESP_SLVERR 2'h2
`endif

// *** design/ctbx_pkg.sv ***
// Types for the transfer, bit and control execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package ctbx_pkg;
  // Instruction codes written by software into the instruction register.
  typedef enum logic [4:0] {
    CTBX_OP_ST_PTR = 5'h00,
    CTBX_OP_ST_POSTINC = 5'h01,
    CTBX_OP_ST_PREDEC = 5'h02,
    CTBX_OP_ST_OFFSET = 5'h03,
    CTBX_OP_ST_DIRECT = 5'h04,
    CTBX_OP_LPM_R0 = 5'h05,
    CTBX_OP_LPM_RD = 5'h06,
    CTBX_OP_LPM_POSTINC = 5'h07,
    CTBX_OP_PUSH = 5'h08,
    CTBX_OP_POP = 5'h09,
    CTBX_OP_IO_RAISE = 5'h0A,
    CTBX_OP_IO_DROP = 5'h0B,
    CTBX_OP_ROL = 5'h0C,
    CTBX_OP_ROR = 5'h0D,
    CTBX_OP_BIT_TO_T = 5'h0E,
    CTBX_OP_T_TO_BIT = 5'h0F,
    CTBX_OP_V_RAISE = 5'h10,
    CTBX_OP_V_DROP = 5'h11,
    CTBX_OP_S_RAISE = 5'h12,
    CTBX_OP_S_DROP = 5'h13,
    CTBX_OP_H_DROP = 5'h14,
    CTBX_OP_T_RAISE = 5'h15,
    CTBX_OP_T_DROP = 5'h16,
    CTBX_OP_SLEEP = 5'h17,
    CTBX_OP_WDR = 5'h18,
    CTBX_OP_BREAK = 5'h19,
    CTBX_OP_IN = 5'h1A,
    CTBX_OP_OUT = 5'h1B,
    CTBX_OP_SWAP = 5'h1C,
    CTBX_OP_NOP = 5'h1D
  } ctbx_op_t;

  // Execution sequencer states.
  typedef enum logic [1:0] {
    CTBX_ST_IDLE = 2'b00,
    CTBX_ST_EXEC = 2'b01,
    CTBX_ST_HALT = 2'b10
  } ctbx_state_t;
endpackage

// *** design/ctbx_core.sv ***
// Execution engine for stores, program loads, stack, I/O bit, rotate, T-flag and control instructions.
// Assumes software issues instructions over AXI4-Lite and outside memories answer within one cycle.
`include "ctbx_regs.svh"

// Notes on behaviour
// - Post-increment store writes source at pointer, then pointer plus one; two cycles.
// - Pre-decrement store subtracts one first, writes at new address; two cycles.
// - Offset store writes at Y or Z plus displacement, pointer kept; two cycles.
// - Direct store writes at address from operand word; two cycles, no flags.
// - Program load reads byte at Z into r0 or register; post-inc bumps Z; three cycles.
// - Push places register on stack, pop takes top; two cycles each, no flags.
// - I/O bit raise or drop forces one bit, others intact; two cycles.
// - Rotate left through carry; updates Z, C, N, V in one cycle.
// - Rotate right through carry; updates Z, C, N, V in one cycle.
// - Bit to T copies a register bit into T only; one cycle.
// - T to bit copies T into a register bit; no flags; one cycle.
// - Overflow raise or drop touches only V; one cycle.
// - Sign raise or drop touches only S; one cycle.
// - Half-carry drop clears only H; one cycle.
// - T raise or drop sets or clears only T; one cycle.
// - Sleep gives a one-cycle request to power management; no flags.
// - Watchdog kick gives a one-cycle restart pulse; no flags.
// - Break signals debug logic to halt, only when debugging is enabled.
module ctbx_core (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Data memory, stack and I/O read and write port.
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic io_we,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Program memory read port.
  output logic [15:0] code_addr,
  input wire logic [7:0] code_rdata,
  // Side-band control.
  output logic sleep_req,
  output logic wdt_restart,
  output logic debug_halt,
  input wire logic debug_enable
);
  ctbx_pkg::ctbx_state_t state_reg;
  logic [1:0] aw_wait_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic [31:0] wdat;
  logic [4:0] op_reg;
  logic [7:0] src_reg;
  logic [2:0] bit_reg;
  logic [5:0] disp_reg;
  logic [15:0] ptr_reg;
  logic [15:0] direct_reg;
  logic [15:0] sp_reg;
  logic [7:0] flags_reg;
  logic [7:0] result_reg;
  logic [4:0] dest_reg;
  logic [1:0] cyc_reg;
  logic [1:0] cyc_len;
  logic start;
  logic done;
  logic dbg_en_meta;
  logic dbg_en_sync;
  logic [7:0] rot_val;

  // Number of cycles each instruction occupies.
  function automatic logic [1:0] ctbx_len(input logic [4:0] op);
    ctbx_pkg::ctbx_op_t o;
    o = ctbx_pkg::ctbx_op_t'(op);
    unique case (o)
      ctbx_pkg::CTBX_OP_ST_PTR, ctbx_pkg::CTBX_OP_ST_POSTINC, ctbx_pkg::CTBX_OP_ST_PREDEC,
      ctbx_pkg::CTBX_OP_ST_OFFSET, ctbx_pkg::CTBX_OP_ST_DIRECT, ctbx_pkg::CTBX_OP_PUSH,
      ctbx_pkg::CTBX_OP_POP, ctbx_pkg::CTBX_OP_IO_RAISE, ctbx_pkg::CTBX_OP_IO_DROP:
        ctbx_len = `CTBX_CYC_TWO;
      ctbx_pkg::CTBX_OP_LPM_R0, ctbx_pkg::CTBX_OP_LPM_RD, ctbx_pkg::CTBX_OP_LPM_POSTINC:
        ctbx_len = `CTBX_CYC_THREE;
      default:
        ctbx_len = `CTBX_CYC_ONE;
    endcase
  endfunction

  // Debug enable comes from the debug domain, so it is synchronised first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_en_meta <= 1'b0;
      dbg_en_sync <= 1'b0;
    end else begin
      dbg_en_meta <= debug_enable;
      dbg_en_sync <= dbg_en_meta;
    end
  end

  // Write channel: address and data are caught in either order, response follows both.
  assign s_axi_awready = !aw_wait_reg[0] && !s_axi_bvalid;
  assign s_axi_wready = !aw_wait_reg[1] && !s_axi_bvalid;
  assign wr_go = (aw_wait_reg[0] || (s_axi_awvalid && s_axi_awready)) &&
                 (aw_wait_reg[1] || (s_axi_wvalid && s_axi_wready));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_wait_reg <= 2'h0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTBX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_wait_reg <= 2'h0;
        s_axi_bvalid <= 1'b1;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_wait_reg[0] <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          aw_wait_reg[1] <= 1'b1;
        end
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      if (wr_go) begin
        s_axi_bresp <= (wr_addr() <= `CTBX_ADDR_SIDE) ? `CTBX_RESP_OKAY : `CTBX_RESP_SLVERR;
      end
    end
  end

  // Address and data as seen in the cycle the write completes.
  function automatic logic [31:0] wr_addr();
    wr_addr = aw_wait_reg[0] ? awaddr_reg : s_axi_awaddr;
  endfunction
  assign wdat = aw_wait_reg[1] ? wdata_reg : s_axi_wdata;

  // A write with bit 0 set to the control word while idle starts the loaded instruction.
  assign start = wr_go && (wr_addr() == `CTBX_ADDR_CTRL) && wdat[0] && (state_reg == ctbx_pkg::CTBX_ST_IDLE);
  assign cyc_len = ctbx_len(op_reg);
  assign done = (state_reg == ctbx_pkg::CTBX_ST_EXEC) && (cyc_reg == cyc_len);

  // Operand registers; writes while busy are ignored so operands stay stable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_reg <= 5'h1D;
      src_reg <= 8'h00;
      bit_reg <= 3'h0;
      disp_reg <= 6'h00;
      dest_reg <= 5'h00;
      direct_reg <= 16'h0000;
    end else if (wr_go && state_reg == ctbx_pkg::CTBX_ST_IDLE) begin
      if (wr_addr() == `CTBX_ADDR_INSN) begin
        op_reg <= wdat[4:0];
        dest_reg <= wdat[12:8];
        bit_reg <= wdat[18:16];
        disp_reg <= wdat[29:24];
      end
      if (wr_addr() == `CTBX_ADDR_OPS) begin
        src_reg <= wdat[7:0];
        direct_reg <= wdat[31:16];
      end
    end
  end

  // Sequencer: counts cycles of the running instruction; break parks in halt while debugging is enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ctbx_pkg::CTBX_ST_IDLE;
      cyc_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        ctbx_pkg::CTBX_ST_IDLE: begin
          if (start) begin
            state_reg <= ctbx_pkg::CTBX_ST_EXEC;
            cyc_reg <= `CTBX_CYC_ONE;
          end
        end
        ctbx_pkg::CTBX_ST_EXEC: begin
          if (done) begin
            state_reg <= (op_reg == ctbx_pkg::CTBX_OP_BREAK && dbg_en_sync) ?
                         ctbx_pkg::CTBX_ST_HALT : ctbx_pkg::CTBX_ST_IDLE;
          end else begin
            cyc_reg <= cyc_reg + 2'h1;
          end
        end
        ctbx_pkg::CTBX_ST_HALT: begin
          if (!dbg_en_sync) begin
            state_reg <= ctbx_pkg::CTBX_ST_IDLE;
          end
        end
        default: state_reg <= ctbx_pkg::CTBX_ST_IDLE;
      endcase
    end
  end

  assign debug_halt = (state_reg == ctbx_pkg::CTBX_ST_HALT);
  assign rot_val = (op_reg == ctbx_pkg::CTBX_OP_ROL) ? {src_reg[6:0], flags_reg[`CTBX_FLAG_C]} :
                   {flags_reg[`CTBX_FLAG_C], src_reg[7:1]};

  // Memory, stack, I/O and program ports act in the last cycle of their instruction.
  always_comb begin
    mem_we = 1'b0;
    mem_addr = ptr_reg;
    mem_wdata = src_reg;
    io_we = 1'b0;
    io_addr = disp_reg;
    io_wdata = src_reg;
    code_addr = ptr_reg;
    if (state_reg == ctbx_pkg::CTBX_ST_EXEC) begin
      unique case (ctbx_pkg::ctbx_op_t'(op_reg))
        ctbx_pkg::CTBX_OP_ST_PTR, ctbx_pkg::CTBX_OP_ST_POSTINC: mem_we = done;
        ctbx_pkg::CTBX_OP_ST_PREDEC: begin
          mem_addr = ptr_reg - 16'h0001;
          mem_we = done;
        end
        ctbx_pkg::CTBX_OP_ST_OFFSET: begin
          mem_addr = ptr_reg + {10'h000, disp_reg};
          mem_we = done;
        end
        ctbx_pkg::CTBX_OP_ST_DIRECT: begin
          mem_addr = direct_reg;
          mem_we = done;
        end
        ctbx_pkg::CTBX_OP_PUSH: begin
          mem_addr = sp_reg;
          mem_we = done;
        end
        ctbx_pkg::CTBX_OP_POP: mem_addr = sp_reg + 16'h0001;
        ctbx_pkg::CTBX_OP_IO_RAISE: begin
          io_wdata = io_rdata | (8'h01 << bit_reg);
          io_we = done;
        end
        ctbx_pkg::CTBX_OP_IO_DROP: begin
          io_wdata = io_rdata & ~(8'h01 << bit_reg);
          io_we = done;
        end
        ctbx_pkg::CTBX_OP_OUT: io_we = done;
        default: mem_we = 1'b0;
      endcase
    end
  end

  // Pointer and stack pointer updates; software may preload the pointer while idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= 16'h0000;
      sp_reg <= 16'hFFFF;
    end else if (wr_go && state_reg == ctbx_pkg::CTBX_ST_IDLE && wr_addr() == `CTBX_ADDR_PTR) begin
      ptr_reg <= wdat[15:0];
      sp_reg <= wdat[31:16];
    end else if (done) begin
      unique case (ctbx_pkg::ctbx_op_t'(op_reg))
        ctbx_pkg::CTBX_OP_ST_POSTINC, ctbx_pkg::CTBX_OP_LPM_POSTINC: ptr_reg <= ptr_reg + 16'h0001;
        ctbx_pkg::CTBX_OP_ST_PREDEC: ptr_reg <= ptr_reg - 16'h0001;
        ctbx_pkg::CTBX_OP_PUSH: sp_reg <= sp_reg - 16'h0001;
        ctbx_pkg::CTBX_OP_POP: sp_reg <= sp_reg + 16'h0001;
        default: ptr_reg <= ptr_reg;
      endcase
    end
  end

  // Register result and its destination index (r0 for the no-operand program load).
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= 8'h00;
    end else if (done) begin
      unique case (ctbx_pkg::ctbx_op_t'(op_reg))
        ctbx_pkg::CTBX_OP_LPM_R0, ctbx_pkg::CTBX_OP_LPM_RD,
        ctbx_pkg::CTBX_OP_LPM_POSTINC: result_reg <= code_rdata;
        ctbx_pkg::CTBX_OP_POP: result_reg <= mem_rdata;
        ctbx_pkg::CTBX_OP_ROL, ctbx_pkg::CTBX_OP_ROR: result_reg <= rot_val;
        ctbx_pkg::CTBX_OP_T_TO_BIT: begin
          result_reg <= src_reg;
          result_reg[bit_reg] <= flags_reg[`CTBX_FLAG_T];
        end
        ctbx_pkg::CTBX_OP_IN: result_reg <= io_rdata;
        ctbx_pkg::CTBX_OP_SWAP: result_reg <= {src_reg[3:0], src_reg[7:4]};
        default: result_reg <= result_reg;
      endcase
    end
  end

  // Status flags; every instruction not listed leaves them alone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= `CTBX_FLAGS_RESET;
    end else if (wr_go && state_reg == ctbx_pkg::CTBX_ST_IDLE && wr_addr() == `CTBX_ADDR_FLAGS) begin
      flags_reg <= wdat[7:0];
    end else if (done) begin
      unique case (ctbx_pkg::ctbx_op_t'(op_reg))
        ctbx_pkg::CTBX_OP_ROL, ctbx_pkg::CTBX_OP_ROR: begin
          flags_reg[`CTBX_FLAG_C] <= (op_reg == ctbx_pkg::CTBX_OP_ROL) ? src_reg[7] : src_reg[0];
          flags_reg[`CTBX_FLAG_Z] <= (rot_val == 8'h00);
          flags_reg[`CTBX_FLAG_N] <= rot_val[7];
          flags_reg[`CTBX_FLAG_V] <= rot_val[7] ^ ((op_reg == ctbx_pkg::CTBX_OP_ROL) ? src_reg[7] : src_reg[0]);
        end
        ctbx_pkg::CTBX_OP_BIT_TO_T: flags_reg[`CTBX_FLAG_T] <= src_reg[bit_reg];
        ctbx_pkg::CTBX_OP_V_RAISE: flags_reg[`CTBX_FLAG_V] <= 1'b1;
        ctbx_pkg::CTBX_OP_V_DROP: flags_reg[`CTBX_FLAG_V] <= 1'b0;
        ctbx_pkg::CTBX_OP_S_RAISE: flags_reg[`CTBX_FLAG_S] <= 1'b1;
        ctbx_pkg::CTBX_OP_S_DROP: flags_reg[`CTBX_FLAG_S] <= 1'b0;
        ctbx_pkg::CTBX_OP_H_DROP: flags_reg[`CTBX_FLAG_H] <= 1'b0;
        ctbx_pkg::CTBX_OP_T_RAISE: flags_reg[`CTBX_FLAG_T] <= 1'b1;
        ctbx_pkg::CTBX_OP_T_DROP: flags_reg[`CTBX_FLAG_T] <= 1'b0;
        default: flags_reg <= flags_reg;
      endcase
    end
  end

  // Side-band pulses last exactly the single execution cycle.
  assign sleep_req = done && (op_reg == ctbx_pkg::CTBX_OP_SLEEP);
  assign wdt_restart = done && (op_reg == ctbx_pkg::CTBX_OP_WDR);

  // Read channel: one read at a time, answered one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CTBX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CTBX_RESP_OKAY;
      unique case (s_axi_araddr)
        `CTBX_ADDR_CTRL: s_axi_rdata <= 32'h0000_0000;
        `CTBX_ADDR_INSN: s_axi_rdata <= {2'h0, disp_reg, 5'h00, bit_reg, 3'h0, dest_reg, 3'h0, op_reg};
        `CTBX_ADDR_OPS: s_axi_rdata <= {direct_reg, 8'h00, src_reg};
        `CTBX_ADDR_FLAGS: s_axi_rdata <= {24'h000000, flags_reg};
        `CTBX_ADDR_STAT: s_axi_rdata <= {28'h0000000, cyc_reg, state_reg};
        `CTBX_ADDR_PTR: s_axi_rdata <= {sp_reg, ptr_reg};
        `CTBX_ADDR_RESULT: s_axi_rdata <= {19'h00000, (op_reg == ctbx_pkg::CTBX_OP_LPM_R0) ? 5'h00 : dest_reg,
                                           result_reg};
        `CTBX_ADDR_MEMOUT: s_axi_rdata <= {mem_wdata, mem_addr, 8'h00};
        `CTBX_ADDR_SIDE: s_axi_rdata <= {29'h00000000, debug_halt, dbg_en_sync, 1'b0};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CTBX_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** tb/ctbx_core_asserts.sv ***
// Checker for the execution block: register writes, memory, I/O and side-band strobes.
// Assumes it is bound to ctbx_core and that the instruction is not rewritten while a run is busy.
`include "ctbx_regs.svh"
module ctbx_core_asserts (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register write channels.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // Memory and I/O strobes.
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic io_we,
  input wire logic [5:0] io_addr,
  // Side-band control.
  input wire logic sleep_req,
  input wire logic wdt_restart,
  input wire logic debug_halt,
  input wire logic debug_enable
);
  logic wr;
  logic go;
  logic [4:0] op_q;
  logic [5:0] disp_q;
  logic [7:0] src_q;
  logic [15:0] dir_q;
  // Only writes whose address and data land together are tracked; split writes would be missed.
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign go = wr && s_axi_awaddr == `CTBX_ADDR_CTRL && s_axi_wdata[0];
  // Shadow of the instruction word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q <= 5'h1D;
      disp_q <= 6'h00;
    end else if (wr && s_axi_awaddr == `CTBX_ADDR_INSN) begin
      op_q <= s_axi_wdata[4:0];
      disp_q <= s_axi_wdata[29:24];
    end
  end
  // Shadow of the operand word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 8'h00;
      dir_q <= 16'h0000;
    end else if (wr && s_axi_awaddr == `CTBX_ADDR_OPS) begin
      src_q <= s_axi_wdata[7:0];
      dir_q <= s_axi_wdata[31:16];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_STORE_TWO: assert property (go && op_q <= 5'h04 |=> !mem_we ##1 mem_we ##1 !mem_we)
    else $error("store write not in second cycle");
  AST_PUSH_TWO: assert property (go && op_q == 5'h08 |=> !mem_we ##1 mem_we ##1 !mem_we)
    else $error("push write not in second cycle");
  AST_IOBIT_TWO: assert property (go && (op_q == 5'h0A || op_q == 5'h0B) |=> !io_we ##1 io_we)
    else $error("bit write not in second cycle");
  AST_OUT_ONE: assert property (go && op_q == 5'h1B |=> io_we ##1 !io_we)
    else $error("port output not in one cycle");
  AST_SLEEP_PULSE: assert property (go && op_q == 5'h17 |=> sleep_req ##1 !sleep_req)
    else $error("sleep request not one cycle");
  AST_WDR_PULSE: assert property (go && op_q == 5'h18 |=> wdt_restart ##1 !wdt_restart)
    else $error("watchdog restart not one cycle");
  AST_LOAD_NOWR: assert property (go && op_q inside {5'h05, 5'h06, 5'h07} |=> (!mem_we && !io_we) [*3])
    else $error("program load wrote memory");
  AST_WDATA: assert property (mem_we |-> mem_wdata == src_q)
    else $error("memory write data differs from source");
  AST_DIRECT: assert property (mem_we && op_q == 5'h04 |-> mem_addr == dir_q)
    else $error("direct store address wrong");
  AST_IOADDR: assert property (io_we |-> io_addr == disp_q)
    else $error("I/O address differs from field");
  AST_DBG_RELEASE: assert property ((!debug_enable) [*5] |-> !debug_halt)
    else $error("halt without debug enabled");
  COV_SLEEP: cover property (go && op_q == 5'h17);
  COV_PUSH: cover property (go && op_q == 5'h08);
  COV_IO: cover property (io_we);
  COV_HALT: cover property (debug_halt);
endmodule

// *** tb/ctbx_core_tb_top.sv ***
// Self-checking bench for the execution block: table of runs, then busy, unmapped, debug and reset cases.
// Assumes the memories answer in the same cycle; the bench supplies their read bytes as constants per run.
`include "ctbx_regs.svh"
module ctbx_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [4:0] op;
    logic [8:0] bq;
    logic [7:0] v;
    logic [7:0] fl;
    logic [15:0] ptr;
    logic [7:0] xfl;
    logic [15:0] xptr;
    logic [1:0] k;
    logic [15:0] ea;
    logic [7:0] ev;
  } ctbx_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, debug_enable = 1'b0;
  logic [7:0] mem_rdata = 8'h0, io_rdata = 8'h0, code_rdata = 8'h0, mem_wdata, io_wdata, md, id;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_we, io_we, sleep_req, wdt_restart, debug_halt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] mem_addr, code_addr, ma;
  logic [5:0] io_addr, ia;
  int mismatches = 0, checked = 0, cyc = 0, mw_n = 0, iw_n = 0, sl_n = 0, wd_n = 0;
  logic [31:0] d;
  logic [1:0] r;
  // Columns: op, bit and displacement, operand byte, flags in, pointer in, flags out, pointer out, kind, addr, value.
  ctbx_row_t rows [31] = '{
    '{5'h00, 9'h0, 8'hA5, 8'hC3, 16'h1234, 8'hC3, 16'h1234, 2'h2, 16'h1234, 8'hA5},
    '{5'h01, 9'h0, 8'h3C, 8'h00, 16'h10FF, 8'h00, 16'h1100, 2'h2, 16'h10FF, 8'h3C},
    '{5'h02, 9'h0, 8'h96, 8'hFF, 16'h2000, 8'hFF, 16'h1FFF, 2'h2, 16'h1FFF, 8'h96},
    '{5'h02, 9'h0, 8'h01, 8'h00, 16'h0000, 8'h00, 16'hFFFF, 2'h2, 16'hFFFF, 8'h01},
    '{5'h03, 9'h03F, 8'h7E, 8'h55, 16'h0100, 8'h55, 16'h0100, 2'h2, 16'h013F, 8'h7E},
    '{5'h04, 9'h0, 8'hE1, 8'hAA, 16'h0007, 8'hAA, 16'h0007, 2'h2, 16'hBEEF, 8'hE1},
    '{5'h05, 9'h0, 8'h00, 8'h0F, 16'h0040, 8'h0F, 16'h0040, 2'h1, 16'h0, 8'h5A},
    '{5'h06, 9'h0, 8'h0F, 8'hF0, 16'h0041, 8'hF0, 16'h0041, 2'h1, 16'h0, 8'h55},
    '{5'h07, 9'h0, 8'hA5, 8'h81, 16'hFFFF, 8'h81, 16'h0000, 2'h1, 16'h0, 8'hFF},
    '{5'h08, 9'h0, 8'h5A, 8'h3C, 16'h0, 8'h3C, 16'h0, 2'h2, 16'hFFFF, 8'h5A},
    '{5'h09, 9'h0, 8'hC3, 8'h00, 16'h0, 8'h00, 16'h0, 2'h1, 16'h0, 8'hC3},
    '{5'h0A, 9'h1E1, 8'hFF, 8'h00, 16'h0, 8'h00, 16'h0, 2'h3, 16'h0021, 8'h80},
    '{5'h0B, 9'h00A, 8'h00, 8'hFF, 16'h0, 8'hFF, 16'h0, 2'h3, 16'h000A, 8'hFE},
    '{5'h0C, 9'h0, 8'h80, 8'hF0, 16'h0, 8'hFB, 16'h0, 2'h1, 16'h0, 8'h00},
    '{5'h0C, 9'h0, 8'h41, 8'h01, 16'h0, 8'h0C, 16'h0, 2'h1, 16'h0, 8'h83},
    '{5'h0D, 9'h0, 8'h01, 8'h01, 16'h0, 8'h05, 16'h0, 2'h1, 16'h0, 8'h80},
    '{5'h0E, 9'h0C0, 8'hF7, 8'hFF, 16'h0, 8'hBF, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h0F, 9'h1C0, 8'h00, 8'hFF, 16'h0, 8'hFF, 16'h0, 2'h1, 16'h0, 8'h80},
    '{5'h10, 9'h0, 8'h0, 8'h00, 16'h0, 8'h08, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h11, 9'h0, 8'h0, 8'hFF, 16'h0, 8'hF7, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h12, 9'h0, 8'h0, 8'h00, 16'h0, 8'h10, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h13, 9'h0, 8'h0, 8'hFF, 16'h0, 8'hEF, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h14, 9'h0, 8'h0, 8'hFF, 16'h0, 8'hDF, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h15, 9'h0, 8'h0, 8'h00, 16'h0, 8'h40, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h16, 9'h0, 8'h0, 8'hFF, 16'h0, 8'hBF, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h1A, 9'h0, 8'h3C, 8'h99, 16'h0, 8'h99, 16'h0, 2'h1, 16'h0, 8'hC3},
    '{5'h1B, 9'h015, 8'h77, 8'h66, 16'h0, 8'h66, 16'h0, 2'h3, 16'h0015, 8'h77},
    '{5'h1C, 9'h0, 8'h9E, 8'hAA, 16'h0, 8'hAA, 16'h0, 2'h1, 16'h0, 8'hE9},
    '{5'h17, 9'h0, 8'h0, 8'h5A, 16'h0, 8'h5A, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h18, 9'h0, 8'h0, 8'hA5, 16'h0, 8'hA5, 16'h0, 2'h0, 16'h0, 8'h0},
    '{5'h19, 9'h0, 8'h0, 8'h33, 16'h0, 8'h33, 16'h0, 2'h0, 16'h0, 8'h0}
  };
  // Byte enables and response readies are held constant; the slave ignores strobes.
  ctbx_core dut (.s_axi_wstrb(4'hF), .s_axi_bready(1'b1), .s_axi_rready(1'b1), .*);
  always #10 aclk = ~aclk;
  // Strobes are captured at the falling edge, where the combinational outputs have settled.
  always @(negedge aclk) begin
    if (mem_we) begin
      mw_n++;
      ma = mem_addr;
      md = mem_wdata;
    end
    if (io_we) begin
      iw_n++;
      ia = io_addr;
      id = io_wdata;
    end
    sl_n += sleep_req;
    wd_n += wdt_restart;
  end
  // A hang is cut short well beyond the several hundred cycles the run needs.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Readies are looked at on the falling edge, so the decision matches what the rising edge takes.
  task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, got;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta |= s_axi_awvalid && s_axi_awready;
      tw |= s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge aclk);
      got = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (!got);
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic got;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      got = s_axi_arready;
      @(posedge aclk);
    end while (!got);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      got = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (!got);
  endtask
  task automatic idle();
    do axr(`CTBX_ADDR_STAT, d, r);
    while (d[1:0] == 2'h1);
  endtask
  // One run: load flags, pointer, operands and instruction, start, then read back and compare.
  task automatic run(input ctbx_row_t t);
    int m, i, s, w;
    mem_rdata <= t.v;
    io_rdata <= ~t.v;
    code_rdata <= t.v ^ 8'h5A;
    axw(`CTBX_ADDR_FLAGS, {24'h0, t.fl}, r);
    axw(`CTBX_ADDR_PTR, {16'hFFFF, t.ptr}, r);
    axw(`CTBX_ADDR_OPS, {t.ea, 8'h00, t.v}, r);
    axw(`CTBX_ADDR_INSN, {2'h0, t.bq[5:0], 5'h00, t.bq[8:6], 3'h0, 5'h03, 3'h0, t.op}, r);
    m = mw_n;
    i = iw_n;
    s = sl_n;
    w = wd_n;
    axw(`CTBX_ADDR_CTRL, 32'h1, r);
    idle();
    axr(`CTBX_ADDR_FLAGS, d, r);
    chk(32'(d[7:0]), 32'(t.xfl));
    axr(`CTBX_ADDR_PTR, d, r);
    chk(32'(d[15:0]), 32'(t.xptr));
    if (t.k == 2'h1) axr(`CTBX_ADDR_RESULT, d, r);
    if (t.k == 2'h1) chk(32'(d[7:0]), 32'(t.ev));
    chk(32'(mw_n - m), 32'(t.k == 2'h2));
    chk(32'(iw_n - i), 32'(t.k == 2'h3));
    if (t.k == 2'h2) chk({ma, md, 8'h0}, {t.ea, t.ev, 8'h0});
    if (t.k == 2'h3) chk({ia, id}, {t.ea[5:0], t.ev});
    chk(32'(sl_n - s), 32'(t.op == 5'h17));
    chk(32'(wd_n - w), 32'(t.op == 5'h18));
  endtask
  // Main sequence: table first, then the hand-written cases.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[n]) run(rows[n]);
    // A flag write landing in the second cycle of a program load must be dropped.
    axw(`CTBX_ADDR_FLAGS, 32'h12, r);
    axw(`CTBX_ADDR_INSN, 32'h6, r);
    axw(`CTBX_ADDR_CTRL, 32'h1, r);
    axw(`CTBX_ADDR_FLAGS, 32'hFF, r);
    idle();
    axr(`CTBX_ADDR_FLAGS, d, r);
    chk(32'(d[7:0]), 32'h12);
    // Unmapped word in both directions.
    axw(32'h40, 32'h0, r);
    chk(32'(r), 32'(`CTBX_RESP_SLVERR));
    axr(32'h40, d, r);
    chk(32'(r), 32'(`CTBX_RESP_SLVERR));
    // Break with debugging enabled halts and refuses writes until the enable drops.
    debug_enable <= 1'b1;
    repeat (4) @(posedge aclk);
    axw(`CTBX_ADDR_FLAGS, 32'h3C, r);
    axw(`CTBX_ADDR_INSN, 32'h19, r);
    axw(`CTBX_ADDR_CTRL, 32'h1, r);
    repeat (3) @(posedge aclk);
    axr(`CTBX_ADDR_SIDE, d, r);
    chk(32'(d[2:1]), 32'h3);
    axw(`CTBX_ADDR_FLAGS, 32'hFF, r);
    axr(`CTBX_ADDR_FLAGS, d, r);
    chk(32'(d[7:0]), 32'h3C);
    debug_enable <= 1'b0;
    repeat (6) @(posedge aclk);
    idle();
    chk(32'(d[1:0]), 32'h0);
    // Reset while idle restores the documented starting values.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`CTBX_ADDR_FLAGS, d, r);
    chk(d, 32'(`CTBX_FLAGS_RESET));
    axr(`CTBX_ADDR_PTR, d, r);
    chk(d, 32'hFFFF0000);
    finish_test();
  end
endmodule
bind ctbx_core ctbx_core_asserts u_chk (.*);
